// ### logic/sff_pkg.sv
// Package with register map, field positions, reset values and carrier types of the serial unit.
package sff_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int SFF_ADDR_W = 8;
	localparam logic [7:0] SFF_OFS_MODE = 8'h00;
	localparam logic [7:0] SFF_OFS_DIVISOR = 8'h04;
	localparam logic [7:0] SFF_OFS_DATA = 8'h08;
	localparam logic [7:0] SFF_OFS_STATUS = 8'h0c;
	localparam logic [7:0] SFF_OFS_CTRL = 8'h10;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] SFF_MODE_RST = 8'h00;
	localparam logic [7:0] SFF_DIVISOR_RST = 8'h00;
	localparam logic [7:0] SFF_CTRL_RST = 8'h00;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int SFF_ST_TX_FULL = 0;
	localparam int SFF_ST_TX_BUSY = 1;
	localparam int SFF_ST_RX_FULL = 2;
	localparam int SFF_ST_OVERRUN = 3;
	localparam int SFF_ST_FRAMING = 4;
	localparam int SFF_ST_PARITY = 5;
	localparam int SFF_ST_RX_MPB = 6;
	localparam int SFF_CTRL_TX_MPB = 0;

	// ****************************************
	// Counts
	// ****************************************
	localparam logic [3:0] SFF_OVS_LAST = 4'hf;
	localparam logic [3:0] SFF_OVS_MID = 4'h7;
	localparam logic [3:0] SFF_SYNC_LAST = 4'h1;
	localparam logic [2:0] SFF_LAST_BIT8 = 3'h7;
	localparam logic [2:0] SFF_LAST_BIT7 = 3'h6;
	localparam logic [5:0] SFF_PRE_DIV4 = 6'h03;
	localparam logic [5:0] SFF_PRE_DIV16 = 6'h0f;
	localparam logic [5:0] SFF_PRE_DIV64 = 6'h3f;
	localparam int SFF_FIFO_DEPTH = 8;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic sync_mode;
		logic char_len_seven;
		logic parity_enable;
		logic parity_odd_select;
		logic stop_two;
		logic multiprocessor_framing;
		logic baud_prescale_sel_hi;
		logic baud_prescale_sel_lo;
	} sff_mode_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [SFF_ADDR_W-1:0] addr;
		logic [7:0] wdata;
	} sff_bus_req_s;

endpackage : sff_pkg

// ### logic/sff_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module sff_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	import sff_pkg::*;

	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;
	logic push;
	logic pop;

	assign in_ready = (count != DEPTH[PW:0]);
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = ce && in_valid && in_ready;
	assign pop = ce && out_valid && out_ready;

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end

	a_fifo_no_over: assert property (@(posedge mclk) disable iff (!rst_b) count <= DEPTH[PW:0])
		else $error("FIFO count above depth");

endmodule : sff_fifo

// ### logic/sff_serial_unit.sv
// Serial unit with frame-format register, baud generator, transmit FIFO, transmitter and receiver.
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ns

// Summary of operation
// R01: Bit 7 selects asynchronous or clocked synchronous.
// R02: Asynchronous: bit 6 picks 8 or 7 bits.
// R03: Bit 5 adds and checks a parity bit.
// R04: Bit 4 picks even or odd parity.
// R05: Bit 3 sends one or two stop bits.
// R06: Receiver checks only the first stop bit.
// R07: Low after first stop starts next character.
// R08: Bit 2 multiprocessor framing overrides parity settings.
// R09: Software keeps bit 2 clear in synchronous mode.
// R10: Codes 01,10,11 divide clock by 4,16,64.
// R11: Length, parity, stop ignored in synchronous mode.
// R12: Characters leave least significant bit first.
// R13: Code 00 undivided; mode resets to zero.
module sff_serial_unit (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	input wire sff_pkg::sff_bus_req_s bus_req,
	output logic [7:0] rd_data,
	input wire logic rxd,
	output logic txd,
	output logic sck_out,
	output logic sck_oe
);
	import sff_pkg::*;

	// Every check in this module runs on the one system clock and sleeps through reset.
	default clocking sff_cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_EXTRA, TX_STOP1, TX_STOP2} sff_tx_e;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_EXTRA, RX_STOP} sff_rx_e;

	// Even parity over the active character bits; odd inverts it.
	function automatic logic sff_parity(input logic [7:0] d, input logic seven, input logic odd);
		logic p;
		p = ^d[6:0];
		if (!seven) begin
			p = p ^ d[7];
		end
		return p ^ odd;
	endfunction : sff_parity

	// ****************************************
	// Registers
	// ****************************************
	sff_mode_s mode;
	logic [7:0] divisor;
	logic [7:0] ctrl;
	logic [7:0] rx_data;
	logic rx_full;
	logic overrun;
	logic framing_err;
	logic parity_err;
	logic rx_mpb;

	logic hit_wr_mode;
	logic hit_rd_data;
	logic hit_wr_status;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic tx_load;

	logic sync_m;
	logic seven;
	logic par_on;
	logic mp_on;
	logic [2:0] last_bit;

	assign hit_wr_mode = bus_req.wr && bus_req.addr == SFF_OFS_MODE;
	assign hit_rd_data = bus_req.rd && bus_req.addr == SFF_OFS_DATA;
	assign hit_wr_status = bus_req.wr && bus_req.addr == SFF_OFS_STATUS;

	assign sync_m = mode.sync_mode; // R01
	assign seven = !sync_m && mode.char_len_seven; // R02 R11
	assign mp_on = mode.multiprocessor_framing; // R08
	assign par_on = !sync_m && mode.parity_enable && !mp_on; // R03 R08 R11
	assign last_bit = seven ? SFF_LAST_BIT7 : SFF_LAST_BIT8; // R02

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mode <= SFF_MODE_RST; // R13
			divisor <= SFF_DIVISOR_RST;
			ctrl <= SFF_CTRL_RST;
		end else if (ce && bus_req.wr) begin
			if (hit_wr_mode) begin
				mode <= bus_req.wdata;
			end
			if (bus_req.addr == SFF_OFS_DIVISOR) begin
				divisor <= bus_req.wdata;
			end
			if (bus_req.addr == SFF_OFS_CTRL) begin
				ctrl <= bus_req.wdata;
			end
		end
	end

	sff_tx_e tx_state;
	logic [7:0] next_status;

	always_comb begin
		next_status = 8'h00;
		next_status[SFF_ST_TX_FULL] = !fifo_in_ready;
		next_status[SFF_ST_TX_BUSY] = (tx_state != TX_IDLE) || fifo_out_valid;
		next_status[SFF_ST_RX_FULL] = rx_full;
		next_status[SFF_ST_OVERRUN] = overrun;
		next_status[SFF_ST_FRAMING] = framing_err;
		next_status[SFF_ST_PARITY] = parity_err;
		next_status[SFF_ST_RX_MPB] = rx_mpb;
	end

	// Read data stand for exactly one cycle; unmapped offsets read zero.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data <= 8'h00;
		end else if (ce) begin
			rd_data <= 8'h00;
			if (bus_req.rd) begin
				case (bus_req.addr)
					SFF_OFS_MODE: rd_data <= mode;
					SFF_OFS_DIVISOR: rd_data <= divisor;
					SFF_OFS_DATA: rd_data <= rx_data;
					SFF_OFS_STATUS: rd_data <= next_status;
					SFF_OFS_CTRL: rd_data <= ctrl;
					default: rd_data <= 8'h00;
				endcase
			end
		end
	end

	// ****************************************
	// Baud rate generator
	// ****************************************
	logic [5:0] presc;
	logic [5:0] pre_mask;
	logic pre_tick;
	logic [7:0] brg;
	logic tick;

	always_comb begin
		case ({mode.baud_prescale_sel_hi, mode.baud_prescale_sel_lo})
			2'b01: pre_mask = SFF_PRE_DIV4; // R10
			2'b10: pre_mask = SFF_PRE_DIV16; // R10
			2'b11: pre_mask = SFF_PRE_DIV64; // R10
			default: pre_mask = 6'h00; // R13
		endcase
	end
	assign pre_tick = (presc & pre_mask) == pre_mask;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			presc <= 6'h00;
			brg <= 8'h00;
			tick <= 1'b0;
		end else if (ce) begin
			presc <= presc + 6'h01;
			tick <= 1'b0;
			if (pre_tick) begin
				if (brg >= divisor) begin
					brg <= 8'h00;
					tick <= 1'b1;
				end else begin
					brg <= brg + 8'h01;
				end
			end
		end
	end

	a_prescale_div64: assert property (ce && pre_tick && mode[1:0] == 2'b11 |-> presc == 6'h3f) // R10
		else $error("Divide-by-64 prescaler ticked early");

	// ****************************************
	// Transmit FIFO
	// ****************************************
	// A write to the data register while the FIFO is full is dropped; software watches the full flag.
	sff_fifo #(
		.WIDTH(8),
		.DEPTH(SFF_FIFO_DEPTH)
	) u_tx_fifo (
		.mclk(mclk),
		.rst_b(rst_b),
		.ce(ce),
		.in_valid(bus_req.wr && bus_req.addr == SFF_OFS_DATA),
		.in_ready(fifo_in_ready),
		.in_data(bus_req.wdata),
		.out_valid(fifo_out_valid),
		.out_ready(tx_load),
		.out_data(fifo_out_data)
	);

	// ****************************************
	// Transmitter
	// ****************************************
	logic [3:0] tx_sub;
	logic [2:0] tx_bits;
	logic [7:0] tx_shift;
	logic tx_extra;
	logic tx_bit_end;
	logic tx_stop2;

	assign tx_bit_end = tick && tx_sub == (sync_m ? SFF_SYNC_LAST : SFF_OVS_LAST);
	assign tx_load = tick && tx_state == TX_IDLE && fifo_out_valid;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tx_state <= TX_IDLE;
			tx_sub <= 4'h0;
			tx_bits <= 3'h0;
			tx_shift <= 8'h00;
			tx_extra <= 1'b0;
			tx_stop2 <= 1'b0;
			txd <= 1'b1;
		end else if (ce) begin
			if (tick) begin
				tx_sub <= tx_bit_end ? 4'h0 : tx_sub + 4'h1;
			end
			case (tx_state)
				TX_IDLE: begin
					tx_sub <= 4'h0;
					if (tx_load) begin
						tx_bits <= 3'h0;
						tx_stop2 <= !sync_m && mode.stop_two; // R05 R11
						tx_extra <= mp_on ? ctrl[SFF_CTRL_TX_MPB] :
							sff_parity(fifo_out_data, seven, mode.parity_odd_select); // R04 R08
						if (sync_m) begin
							tx_state <= TX_DATA;
							txd <= fifo_out_data[0]; // R12
							tx_shift <= {1'b0, fifo_out_data[7:1]};
						end else begin
							tx_state <= TX_START;
							txd <= 1'b0;
							tx_shift <= fifo_out_data;
						end
					end
				end
				TX_START: begin
					if (tx_bit_end) begin
						tx_state <= TX_DATA;
						txd <= tx_shift[0]; // R12
						tx_shift <= {1'b0, tx_shift[7:1]};
					end
				end
				TX_DATA: begin
					if (tx_bit_end) begin
						if (tx_bits != last_bit) begin
							tx_bits <= tx_bits + 3'h1;
							txd <= tx_shift[0]; // R12
							tx_shift <= {1'b0, tx_shift[7:1]};
						end else if (par_on || (mp_on && !sync_m)) begin
							tx_state <= TX_EXTRA; // R03 R08
							txd <= tx_extra;
						end else if (sync_m) begin
							tx_state <= TX_IDLE;
							txd <= 1'b1;
						end else begin
							tx_state <= TX_STOP1;
							txd <= 1'b1;
						end
					end
				end
				TX_EXTRA: begin
					if (tx_bit_end) begin
						tx_state <= TX_STOP1;
						txd <= 1'b1;
					end
				end
				TX_STOP1: begin
					if (tx_bit_end) begin
						tx_state <= tx_stop2 ? TX_STOP2 : TX_IDLE; // R05
					end
				end
				TX_STOP2: begin
					if (tx_bit_end) begin
						tx_state <= TX_IDLE;
					end
				end
				default: tx_state <= TX_IDLE;
			endcase
		end
	end

	// Synchronous mode drives its own clock: low for the first half of each bit, idle high.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sck_out <= 1'b1;
			sck_oe <= 1'b0;
		end else if (ce) begin
			sck_oe <= sync_m; // R01
			sck_out <= !(sync_m && tx_state == TX_DATA) || tx_sub[0];
		end
	end

	a_stop_is_high: assert property (ce && tx_state == TX_STOP1 |-> txd) // R05
		else $error("Stop bit not high");
	a_two_stop_bits: assert property (ce && tx_state == TX_STOP1 && tx_bit_end && tx_stop2 |=> tx_state == TX_STOP2) // R05
		else $error("Second stop bit missing");
	a_seven_bit_end: assert property (ce && tx_state == TX_DATA && tx_bit_end && tx_bits == 3'h6 && seven
		|=> tx_state != TX_DATA) // R02
		else $error("Seven-bit character ran long");
	a_sync_eight_bits: assert property (ce && sync_m && tx_state == TX_DATA && tx_bit_end && tx_bits == 3'h6
		|=> tx_state == TX_DATA) // R11
		else $error("Synchronous character shorter than eight bits");
	a_lsb_first_out: assert property (ce && tx_state == TX_START && tx_bit_end |=> txd == $past(tx_shift[0])) // R12
		else $error("First data bit is not the LSB");
	a_mp_no_parity: assert property (mp_on |-> !par_on) // R08
		else $error("Parity active under multiprocessor framing");

	// ****************************************
	// Receiver
	// ****************************************
	logic rxd_meta;
	logic rxd_s;
	sff_rx_e rx_state;
	logic [3:0] rx_sub;
	logic [2:0] rx_bits;
	logic [7:0] rx_shift;
	logic rx_extra;
	logic deliver;
	logic [7:0] deliver_data;
	logic deliver_fer;
	logic deliver_per;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rxd_meta <= 1'b1;
			rxd_s <= 1'b1;
		end else if (ce) begin
			rxd_meta <= rxd;
			rxd_s <= rxd_meta;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rx_state <= RX_IDLE;
			rx_sub <= 4'h0;
			rx_bits <= 3'h0;
			rx_shift <= 8'h00;
			rx_extra <= 1'b0;
			deliver <= 1'b0;
			deliver_data <= 8'h00;
			deliver_fer <= 1'b0;
			deliver_per <= 1'b0;
		end else if (ce) begin
			deliver <= 1'b0;
			if (sync_m) begin
				// Data are sampled as the own clock rises, then the character goes out whole.
				rx_state <= RX_IDLE;
				if (tick && tx_state == TX_DATA && tx_sub == 4'h0) begin
					rx_shift <= {rxd_s, rx_shift[7:1]};
					if (tx_bits == SFF_LAST_BIT8) begin
						deliver <= 1'b1;
						deliver_data <= {rxd_s, rx_shift[7:1]};
						deliver_fer <= 1'b0;
						deliver_per <= 1'b0;
					end
				end
			end else if (tick) begin
				rx_sub <= rx_sub + 4'h1;
				case (rx_state)
					RX_IDLE: begin
						rx_sub <= 4'h0;
						if (!rxd_s) begin
							rx_state <= RX_START; // R07
						end
					end
					RX_START: begin
						if (rx_sub == SFF_OVS_MID) begin
							rx_sub <= 4'h0;
							rx_bits <= 3'h0;
							rx_state <= rxd_s ? RX_IDLE : RX_DATA;
						end
					end
					RX_DATA: begin
						if (rx_sub == SFF_OVS_LAST) begin
							rx_shift <= {rxd_s, rx_shift[7:1]}; // R12
							rx_bits <= rx_bits + 3'h1;
							if (rx_bits == last_bit) begin
								rx_state <= (par_on || mp_on) ? RX_EXTRA : RX_STOP; // R03 R08
							end
						end
					end
					RX_EXTRA: begin
						if (rx_sub == SFF_OVS_LAST) begin
							rx_extra <= rxd_s;
							rx_state <= RX_STOP;
						end
					end
					RX_STOP: begin
						// Only the first stop bit is looked at; a low level after it is a new start.
						if (rx_sub == SFF_OVS_LAST) begin
							rx_state <= RX_IDLE; // R06 R07
							deliver <= 1'b1;
							deliver_data <= seven ? {1'b0, rx_shift[7:1]} : rx_shift; // R02
							deliver_fer <= !rxd_s; // R06
							deliver_per <= par_on &&
								(rx_extra != sff_parity(seven ? {1'b0, rx_shift[7:1]} : rx_shift,
								seven, mode.parity_odd_select)); // R03 R04
						end
					end
					default: rx_state <= RX_IDLE;
				endcase
			end
		end
	end

	// Flags set by a delivered character win over a clear in the same cycle.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rx_data <= 8'h00;
			rx_full <= 1'b0;
			overrun <= 1'b0;
			framing_err <= 1'b0;
			parity_err <= 1'b0;
			rx_mpb <= 1'b0;
		end else if (ce) begin
			if (deliver) begin
				rx_full <= 1'b1;
				if (rx_full && !hit_rd_data) begin
					overrun <= 1'b1;
				end else begin
					rx_data <= deliver_data;
					rx_mpb <= mp_on && rx_extra; // R08
				end
			end else if (hit_rd_data) begin
				rx_full <= 1'b0;
			end
			if (hit_wr_status && bus_req.wdata[SFF_ST_OVERRUN] && !(deliver && rx_full && !hit_rd_data)) begin
				overrun <= 1'b0;
			end
			framing_err <= (deliver && deliver_fer) || (framing_err &&
				!(hit_wr_status && bus_req.wdata[SFF_ST_FRAMING]));
			parity_err <= (deliver && deliver_per) || (parity_err &&
				!(hit_wr_status && bus_req.wdata[SFF_ST_PARITY]));
		end
	end

	a_rx_one_stop: assert property (ce && tick && !sync_m && rx_state == RX_STOP && rx_sub == 4'hf
		|=> rx_state == RX_IDLE && deliver) // R06
		else $error("Receiver did not finish after first stop bit");
	a_rx_next_start: assert property (ce && tick && !sync_m && rx_state == RX_IDLE && !rxd_s
		|=> rx_state == RX_START) // R07
		else $error("Low level after stop not taken as start");
	a_sck_follows_mode: assert property (ce |=> sck_oe == $past(mode.sync_mode)) // R01
		else $error("Clock output enable does not follow mode");

endmodule : sff_serial_unit

// ### bench/sff_remote_uart.sv
// Remote serial partner that drives the receive line and samples the transmit line.
`timescale 1ns/1ns
module sff_remote_uart (
	input wire logic mclk,
	input wire logic txd,
	input wire logic sck_out,
	output logic rxd
);
	// ****
	// Line tasks
	// ****
	// The line rests high between frames, as an idle asynchronous line does.
	initial rxd = 1'b1;

	// Without release the line keeps the last bit, so a following frame starts in the same step.
	task automatic send(input logic [15:0] b, input int n, input int per, input logic rel);
		for (int i = 0; i < n; i++) begin
			rxd <= b[i];
			repeat (per) @(posedge mclk);
		end
		if (rel) begin
			rxd <= 1'b1;
		end
	endtask : send

	task automatic wait_fall();
		for (int t = 0; t < 40000 && txd !== 1'b0; t++) begin
			@(negedge mclk);
		end
	endtask : wait_fall

	// Sampling on the falling clock edge keeps clear of the edge that moves the pin.
	task automatic low_len(output int n);
		wait_fall();
		n = 0;
		while (txd === 1'b0 && n < 5000) begin
			@(negedge mclk);
			n++;
		end
	endtask : low_len

	task automatic grab(input int n, input int per, output logic [15:0] b);
		b = '1;
		wait_fall();
		repeat (per / 2) @(negedge mclk);
		for (int i = 0; i < n; i++) begin
			b[i] = txd;
			repeat (per) @(negedge mclk);
		end
	endtask : grab

	task automatic grab_sync(output logic [15:0] b);
		logic p;
		int i;
		int t;
		b = '1;
		p = sck_out;
		i = 0;
		for (t = 0; i < 8 && t < 40000; t++) begin
			@(negedge mclk);
			if (sck_out && !p) begin
				b[i] = txd;
				i++;
			end
			p = sck_out;
		end
	endtask : grab_sync
endmodule : sff_remote_uart

// ### bench/sff_serial_unit_test.sv
// Self-checking bench for the serial unit: registers, prescaler, frame formats and buffering.
`timescale 1ns/1ns
module sff_serial_unit_test;
	import sff_pkg::*;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	sff_bus_req_s req = '0;
	logic [7:0] rd_data;
	logic rxd;
	logic txd;
	logic sck_out;
	logic sck_oe;
	logic [7:0] v;
	logic [15:0] b;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	int n;
	int per;

	always #50 mclk = ~mclk;

	sff_serial_unit DUT (.mclk(mclk), .rst_b(rst_b), .ce(ce), .bus_req(req), .rd_data(rd_data),
		.rxd(rxd), .txd(txd), .sck_out(sck_out), .sck_oe(sck_oe));
	sff_remote_uart peer (.mclk(mclk), .txd(txd), .sck_out(sck_out), .rxd(rxd));

	// ****
	// Access and compare tasks
	// ****
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk);
		req <= '0;
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [7:0] mk, input logic [7:0] e, input string what);
		@(posedge mclk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge mclk);
		req <= '0;
		@(negedge mclk);
		v = rd_data;
		chk({8'h00, v & mk}, {8'h00, e}, what);
	endtask : rc

	// Expected bit train: start, data, extra bit, first stop, then the slot after it.
	function automatic int frame(input logic [7:0] m, input logic [7:0] d, input logic mpb, output logic [15:0] f);
		int k;
		logic [7:0] dm;
		dm = m[6] ? {1'b0, d[6:0]} : d;
		f = '1;
		f[0] = 1'b0;
		for (int i = 0; i < 8; i++) f[1 + i] = dm[i];
		k = m[6] ? 8 : 9;
		if (m[2] || m[5]) begin
			f[k] = m[2] ? mpb : (^dm ^ m[4]);
			k++;
		end
		f[k] = 1'b1;
		f[k + 1] = m[3];
		return k + 2;
	endfunction : frame

	// Two characters are queued so that one stop bit shows as the next start in the last slot.
	task automatic tx_case(input logic [7:0] m, input logic [7:0] d, input logic mpb);
		logic [15:0] e;
		logic [15:0] g;
		logic [15:0] mk;
		int k;
		k = frame(m, d, mpb, e);
		mk = 16'hffff >> (16 - k);
		wr(SFF_OFS_CTRL, {7'h00, mpb});
		wr(SFF_OFS_MODE, m);
		wr(SFF_OFS_DATA, d);
		wr(SFF_OFS_DATA, d);
		peer.grab(k, per, g);
		chk(g & mk, e & mk, "tx frame");
		repeat ((k + 2) * per) @(posedge mclk);
	endtask : tx_case

	task automatic rx_case(input logic [7:0] m, input logic [7:0] d, input logic mpb, input int flip,
		input int twice, input logic [7:0] ed, input logic [7:0] es);
		logic [15:0] f;
		int k;
		k = frame(m, d, mpb, f);
		if (flip >= 0) f[flip] = ~f[flip];
		wr(SFF_OFS_MODE, m);
		peer.send(f, k - 1, per, twice == 0);
		if (twice != 0) peer.send(f, k - 1, per, 1'b1);
		repeat (2 * per) @(posedge mclk);
		rc(SFF_OFS_STATUS, 8'h7c, es, "rx status");
		rc(SFF_OFS_DATA, 8'hff, ed, "rx data");
		wr(SFF_OFS_STATUS, 8'h38);
	endtask : rx_case

	// ****
	// Sequence
	// ****
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			give_verdict();
		end
	end

	initial begin
		per = 32;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		rc(SFF_OFS_MODE, 8'hff, 8'h00, "mode reset");
		rc(SFF_OFS_DIVISOR, 8'hff, 8'h00, "divisor reset");
		rc(SFF_OFS_CTRL, 8'hff, 8'h00, "ctrl reset");
		wr(8'h14, 8'hff);
		rc(8'h14, 8'hff, 8'h00, "unmapped");
		wr(SFF_OFS_MODE, 8'h5b);
		rc(SFF_OFS_MODE, 8'hff, 8'h5b, "mode readback");
		wr(SFF_OFS_DIVISOR, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr(SFF_OFS_MODE, c[7:0]);
			wr(SFF_OFS_DATA, 8'h01);
			peer.low_len(n);
			chk(n[15:0], 16'd16 << (2 * c), "bit time");
			repeat (12 * (16 << (2 * c))) @(posedge mclk);
		end
		wr(SFF_OFS_DIVISOR, 8'h01);
		tx_case(8'h00, 8'ha5, 1'b0);
		tx_case(8'h08, 8'ha5, 1'b0);
		tx_case(8'h40, 8'hd3, 1'b0);
		tx_case(8'h20, 8'hb1, 1'b0);
		tx_case(8'h30, 8'hb1, 1'b0);
		tx_case(8'h34, 8'hb1, 1'b1);
		// Synchronous mode with seven bits, parity and two stop bits set, even parity and the multiprocessor bit kept clear.
		wr(SFF_OFS_MODE, 8'he8);
		wr(SFF_OFS_DATA, 8'h96);
		peer.grab_sync(b);
		chk(b, 16'hff96, "sync frame");
		chk({15'h0, sck_oe}, 16'h0001, "sck driven");
		repeat (20 * per) @(posedge mclk);
		// The idle receive line is high, so the character clocked in beside the sent one is all ones.
		rc(SFF_OFS_STATUS, 8'h04, 8'h04, "sync rx full");
		rc(SFF_OFS_DATA, 8'hff, 8'hff, "sync rx data");
		wr(SFF_OFS_MODE, 8'h00);
		repeat (2) @(posedge mclk);
		chk({15'h0, sck_oe}, 16'h0000, "sck released");
		rx_case(8'h00, 8'h3c, 1'b0, -1, 0, 8'h3c, 8'h04);
		rx_case(8'h40, 8'hd5, 1'b0, -1, 0, 8'h55, 8'h04);
		rx_case(8'h30, 8'h0f, 1'b0, 9, 0, 8'h0f, 8'h24);
		rx_case(8'h34, 8'h07, 1'b1, -1, 0, 8'h07, 8'h44);
		rx_case(8'h00, 8'h3c, 1'b0, 9, 0, 8'h3c, 8'h14);
		rx_case(8'h08, 8'h3c, 1'b0, -1, 1, 8'h3c, 8'h0c);
		wr(SFF_OFS_DIVISOR, 8'h00);
		// A start bit of 16 cycles stretched by 40 frozen cycles of clock enable.
		wr(SFF_OFS_DATA, 8'h01);
		fork
			peer.low_len(n);
			begin
				repeat (5) @(posedge mclk);
				ce <= 1'b0;
				repeat (40) @(posedge mclk);
				ce <= 1'b1;
			end
		join
		chk(n[15:0], 16'd56, "clock enable freeze");
		repeat (200) @(posedge mclk);
		for (int i = 0; i < 10; i++) wr(SFF_OFS_DATA, i[7:0]);
		rc(SFF_OFS_STATUS, 8'h01, 8'h01, "fifo full");
		repeat (2200) @(posedge mclk);
		rc(SFF_OFS_STATUS, 8'h03, 8'h00, "fifo drained");
		give_verdict();
	end
endmodule : sff_serial_unit_test
